/* File: rtl/startup_pkg.sv */
`default_nettype none
package startup_pkg;

    // Register map, word addresses on the plain register port
    localparam logic [3:0] PMCR_ADDR   = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;

    // Status register layout
    localparam int         STATUS_STRAP_LSB = 0;
    localparam int         STATUS_RUN_BIT   = 4;
    localparam int         STATUS_TAP_BIT   = 5;

    // Power-management control register layout
    localparam int         PM_MULT_LSB = 0;
    localparam int         PM_MULT_W   = 6;
    localparam int         PM_DIV_LSB  = 8;
    localparam int         PM_DIV_W    = 2;
    localparam int         PM_CLKO_BIT = 12;
    localparam logic [1:0] PM_DIV_RST  = 2'h0;

    // Lock wait after the reset pin rises, in input-clock cycles
    localparam int         LOCK_CYCLES = 4096;

    // Core-to-input-clock ratios chosen by the clock-ratio straps
    localparam logic [1:0] RATIO_6     = 2'h0;
    localparam logic [1:0] RATIO_32    = 2'h1;
    localparam logic [1:0] RATIO_16    = 2'h2;
    localparam logic [5:0] MULT_6      = 6'h06;
    localparam logic [5:0] MULT_32     = 6'h20;
    localparam logic [5:0] MULT_16     = 6'h10;

    localparam logic [31:0] RESET_VECTOR = 32'h0008_0004;

    // Test port
    localparam int         IR_W        = 4;
    localparam logic [3:0] IR_RST      = 4'h1;

    typedef struct packed {
        logic [1:0] boot_mode;
        logic [1:0] clk_ratio;
    } straps_t;

    typedef struct packed {
        logic       tck;
        logic       tms;
        logic       tdi;
        logic       trst_n;
    } test_pins_t;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_LOCK,
        ST_RUN
    } boot_state_t;

    function automatic logic [5:0] ratio_mult(input logic [1:0] code);
        case (code)
            RATIO_32: ratio_mult = MULT_32;
            RATIO_16: ratio_mult = MULT_16;
            default:  ratio_mult = MULT_6;
        endcase
    endfunction

endpackage
`default_nettype wire

/* File: rtl/test_port_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module test_port_ctrl
    import startup_pkg::*;
#(
    parameter int CHAIN_W = 8
)(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire test_pins_t         pins_i,
    input  wire logic [CHAIN_W-1:0] capture_i,
    output logic                    scan_out_o,
    output logic                    tap_reset_o
);

    typedef enum logic [3:0] {
        T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR,
        T_EX2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR,
        T_PA_IR, T_EX2_IR, T_UPD_IR
    } tap_state_t;

    typedef struct packed {
        tap_state_t         st;
        logic               tck_prev;
        logic [CHAIN_W-1:0] chain;
        logic [IR_W-1:0]    ir;
        logic               tdo;
    } tap_regs_t;

    tap_regs_t r_q;
    tap_regs_t r_d;
    logic      rise;
    logic      fall;

    assign rise = pins_i.tck & ~r_q.tck_prev;
    assign fall = ~pins_i.tck & r_q.tck_prev;

    always_comb
    begin
        r_d = r_q;
        r_d.tck_prev = pins_i.tck;
        if (rise)
        begin
            case (r_q.st)
                T_RESET:  r_d.st = pins_i.tms ? T_RESET  : T_IDLE;
                T_IDLE:   r_d.st = pins_i.tms ? T_SEL_DR : T_IDLE;
                T_SEL_DR: r_d.st = pins_i.tms ? T_SEL_IR : T_CAP_DR;
                T_CAP_DR: r_d.st = pins_i.tms ? T_EX1_DR : T_SH_DR;
                T_SH_DR:  r_d.st = pins_i.tms ? T_EX1_DR : T_SH_DR;
                T_EX1_DR: r_d.st = pins_i.tms ? T_UPD_DR : T_PA_DR;
                T_PA_DR:  r_d.st = pins_i.tms ? T_EX2_DR : T_PA_DR;
                T_EX2_DR: r_d.st = pins_i.tms ? T_UPD_DR : T_SH_DR;
                T_UPD_DR: r_d.st = pins_i.tms ? T_SEL_DR : T_IDLE;
                T_SEL_IR: r_d.st = pins_i.tms ? T_RESET  : T_CAP_IR;
                T_CAP_IR: r_d.st = pins_i.tms ? T_EX1_IR : T_SH_IR;
                T_SH_IR:  r_d.st = pins_i.tms ? T_EX1_IR : T_SH_IR;
                T_EX1_IR: r_d.st = pins_i.tms ? T_UPD_IR : T_PA_IR;
                T_PA_IR:  r_d.st = pins_i.tms ? T_EX2_IR : T_PA_IR;
                T_EX2_IR: r_d.st = pins_i.tms ? T_UPD_IR : T_SH_IR;
                T_UPD_IR: r_d.st = pins_i.tms ? T_SEL_DR : T_IDLE;
                default:  r_d.st = T_RESET;
            endcase
            case (r_q.st)
                T_CAP_DR: r_d.chain = capture_i;
                T_SH_DR:  r_d.chain = {pins_i.tdi, r_q.chain[CHAIN_W-1:1]};
                T_CAP_IR: r_d.ir = IR_RST;
                T_SH_IR:  r_d.ir = {pins_i.tdi, r_q.ir[IR_W-1:1]};
                default:  r_d.ir = r_q.ir;
            endcase
        end
        if (fall)
        begin
            case (r_q.st)
                T_SH_DR: r_d.tdo = r_q.chain[0];
                T_SH_IR: r_d.tdo = r_q.ir[0];
                default: r_d.tdo = 1'b0;
            endcase
        end
        if (!pins_i.trst_n)
        begin
            r_d.st = T_RESET;
            r_d.ir = IR_RST;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r_q          <= '0;
            r_q.st       <= T_RESET;
            r_q.ir       <= IR_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign scan_out_o  = r_q.tdo;
    assign tap_reset_o = (r_q.st == T_RESET);

endmodule
`default_nettype wire

/* File: rtl/reset_boot_clock_startup.sv */
// Behaviour
// - After reset pin release, wait 4096 input-clock cycles for PLL lock.
// - After the wait, core fetches from the fixed hardware reset vector.
// - Start-up core-to-input-clock ratio comes from the clock-ratio straps.
// - Once running, software may rewrite PLL multiplier and divider anytime.
// - Test-port reset returns the test state machine to its reset state.
// - Test-mode select steers the test machine; test data enters scan path.
// - Boundary scan serial output is driven on the test-data output.
// - Ratio straps: 00 gives 6:1, 01 gives 32:1, 10 gives 16:1.
// - Clock-out pin is reset-out by default; bit 12 selects PLL clock.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module reset_boot_clock_startup
    import startup_pkg::*;
#(
    parameter int CHAIN_W    = 8,
    parameter int LOCK_COUNT = LOCK_CYCLES
)(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        proc_reset_n_i,
    input  wire logic [1:0]  clk_ratio_pins_i,
    input  wire logic [1:0]  boot_select_pins_i,
    input  wire logic        pll_clk_i,
    input  wire logic        test_clk_i,
    input  wire logic        test_mode_sel_i,
    input  wire logic        test_data_i,
    input  wire logic        test_reset_n_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    output logic             core_reset_o,
    output logic             fetch_start_o,
    output logic [31:0]      fetch_addr_o,
    output logic [1:0]       boot_mode_o,
    output logic [5:0]       pll_mult_o,
    output logic [1:0]       pll_div_o,
    output logic             clock_or_reset_out_o,
    output logic             test_data_o
);

    localparam int CNT_W = $clog2(LOCK_COUNT + 1);

    typedef struct packed {
        logic [1:0]  rst_s;
        logic [1:0]  pll_s;
        straps_t     boot_s1;
        straps_t     boot_s2;
        test_pins_t  tp_s1;
        test_pins_t  tp_s2;
        boot_state_t st;
        logic [CNT_W-1:0] cnt;
        straps_t     straps;
        logic [5:0]  mult;
        logic [1:0]  div;
        logic        clko_sel;
        logic        core_rst;
        logic        fetch;
        logic        clk_or_rst;
        logic [31:0] rdata;
    } top_regs_t;

    top_regs_t r_q;
    top_regs_t r_d;
    logic      scan_bit;
    logic      tap_in_reset;
    logic      running;

    assign running = (r_q.st == ST_RUN);

    test_port_ctrl #(
        .CHAIN_W (CHAIN_W)
    ) u_test_port (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .pins_i      (r_q.tp_s2),
        .capture_i   ({{(CHAIN_W-$bits(straps_t)){1'b0}}, r_q.straps}),
        .scan_out_o  (scan_bit),
        .tap_reset_o (tap_in_reset)
    );

    always_comb
    begin
        r_d = r_q;
        // Pins cross into this domain through two flops before use
        r_d.rst_s   = {r_q.rst_s[0], proc_reset_n_i};
        r_d.pll_s   = {r_q.pll_s[0], pll_clk_i};
        r_d.boot_s1 = '{boot_mode: boot_select_pins_i,
                        clk_ratio: clk_ratio_pins_i};
        r_d.boot_s2 = r_q.boot_s1;
        r_d.tp_s1   = '{tck: test_clk_i, tms: test_mode_sel_i,
                        tdi: test_data_i, trst_n: test_reset_n_i};
        r_d.tp_s2   = r_q.tp_s1;
        r_d.fetch   = 1'b0;
        r_d.rdata   = '0;

        case (r_q.st)
            ST_HOLD:
            begin
                r_d.straps   = r_q.boot_s2;
                r_d.mult     = ratio_mult(r_q.boot_s2.clk_ratio);
                r_d.div      = PM_DIV_RST;
                r_d.clko_sel = 1'b0;
                r_d.cnt      = '0;
                r_d.core_rst = 1'b1;
                if (r_q.rst_s[1])
                begin
                    r_d.st = ST_LOCK;
                end
            end
            ST_LOCK:
            begin
                r_d.cnt = r_q.cnt + CNT_W'(1);
                if (r_q.cnt == CNT_W'(LOCK_COUNT - 1))
                begin
                    r_d.st       = ST_RUN;
                    r_d.core_rst = 1'b0;
                    r_d.fetch    = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (reg_wr_i && reg_addr_i == PMCR_ADDR)
                begin
                    r_d.mult     = reg_wdata_i[PM_MULT_LSB +: PM_MULT_W];
                    r_d.div      = reg_wdata_i[PM_DIV_LSB +: PM_DIV_W];
                    r_d.clko_sel = reg_wdata_i[PM_CLKO_BIT];
                end
            end
            default:
            begin
                r_d.st = ST_HOLD;
            end
        endcase

        // Reset pin low restarts the sequence from any state
        if (!r_q.rst_s[1])
        begin
            r_d.st       = ST_HOLD;
            r_d.core_rst = 1'b1;
        end

        r_d.clk_or_rst = r_q.clko_sel ? r_q.pll_s[1] : ~r_q.core_rst;

        if (reg_rd_i)
        begin
            case (reg_addr_i)
                PMCR_ADDR:
                begin
                    r_d.rdata[PM_MULT_LSB +: PM_MULT_W] = r_q.mult;
                    r_d.rdata[PM_DIV_LSB +: PM_DIV_W]   = r_q.div;
                    r_d.rdata[PM_CLKO_BIT]              = r_q.clko_sel;
                end
                STATUS_ADDR:
                begin
                    r_d.rdata[STATUS_STRAP_LSB +: $bits(straps_t)] = r_q.straps;
                    r_d.rdata[STATUS_RUN_BIT] = running;
                    r_d.rdata[STATUS_TAP_BIT] = tap_in_reset;
                end
                default:
                begin
                    r_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r_q          <= '0;
            r_q.st       <= ST_HOLD;
            r_q.core_rst <= 1'b1;
            r_q.mult     <= MULT_6;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign test_data_o          = scan_bit;
    assign reg_rdata_o          = r_q.rdata;
    assign core_reset_o         = r_q.core_rst;
    assign fetch_start_o        = r_q.fetch;
    assign fetch_addr_o         = RESET_VECTOR;
    assign boot_mode_o          = r_q.straps.boot_mode;
    assign pll_mult_o           = r_q.mult;
    assign pll_div_o            = r_q.div;
    assign clock_or_reset_out_o = r_q.clk_or_rst;

endmodule
`default_nettype wire

/* File: bench/startup_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module startup_sva
    import startup_pkg::*;
#(
    parameter int LOCK_COUNT = LOCK_CYCLES
)(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        proc_reset_n_i,
    input wire logic [1:0]  clk_ratio_pins_i,
    input wire logic [1:0]  boot_select_pins_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        core_reset_o,
    input wire logic        fetch_start_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic [1:0]  boot_mode_o,
    input wire logic [5:0]  pll_mult_o,
    input wire logic [1:0]  pll_div_o,
    input wire logic        clock_or_reset_out_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // Cycles the reset pin has been high, saturating
    logic [15:0] high_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !proc_reset_n_i)
            high_q <= 16'h0;
        else if (high_q != 16'hffff)
            high_q <= high_q + 16'h1;
    end

    lock_wait_a: assert property (
        $fell(core_reset_o) |->
        high_q >= LOCK_COUNT && high_q <= LOCK_COUNT + 6)
        else $error("core released outside lock window");
    pin_hold_a: assert property (
        !proc_reset_n_i |-> ##[1:4] core_reset_o)
        else $error("core not held by reset pin");
    fetch_vec_a: assert property (
        $fell(core_reset_o) |-> fetch_start_o && fetch_addr_o == RESET_VECTOR)
        else $error("no fetch from reset vector");
    fetch_once_a: assert property (
        fetch_start_o |=> !fetch_start_o)
        else $error("fetch pulse too long");
    ratio_map_a: assert property (
        $fell(core_reset_o) |-> pll_div_o == 2'h0 && pll_mult_o ==
        (clk_ratio_pins_i == 2'h1 ? 6'h20 :
         clk_ratio_pins_i == 2'h2 ? 6'h10 : 6'h06))
        else $error("start-up ratio wrong");
    boot_take_a: assert property (
        $fell(core_reset_o) |-> boot_mode_o == boot_select_pins_i)
        else $error("boot mode not taken");
    rst_out_a: assert property (
        core_reset_o && $past(core_reset_o) |-> !clock_or_reset_out_o)
        else $error("reset-out released early");
    rst_out_rise_a: assert property (
        $fell(core_reset_o) |=> clock_or_reset_out_o)
        else $error("reset-out not released");
    pmcr_refuse_a: assert property (
        core_reset_o && reg_wr_i |=> $stable(pll_div_o))
        else $error("control write taken in reset");
    pmcr_take_a: assert property (
        !core_reset_o && reg_wr_i && reg_addr_i == PMCR_ADDR |=>
        pll_mult_o == $past(reg_wdata_i[5:0]) &&
        pll_div_o == $past(reg_wdata_i[9:8]))
        else $error("control write not taken");
    rdata_idle_a: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
endmodule

bind reset_boot_clock_startup startup_sva #(.LOCK_COUNT(LOCK_COUNT)) i_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .proc_reset_n_i(proc_reset_n_i),
    .clk_ratio_pins_i(clk_ratio_pins_i),
    .boot_select_pins_i(boot_select_pins_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .core_reset_o(core_reset_o),
    .fetch_start_o(fetch_start_o), .fetch_addr_o(fetch_addr_o),
    .boot_mode_o(boot_mode_o), .pll_mult_o(pll_mult_o),
    .pll_div_o(pll_div_o), .clock_or_reset_out_o(clock_or_reset_out_o));
`default_nettype wire

/* File: bench/board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module board_model
    import startup_pkg::*;
(
    input  wire logic  sys_clk_i,
    output logic       proc_reset_n_o,
    output logic [1:0] clk_ratio_o,
    output logic [1:0] boot_sel_o,
    output logic       pll_clk_o,
    output test_pins_t test_o,
    input  wire logic  tdo_i
);
    initial
    begin
        proc_reset_n_o = 1'b0;
        clk_ratio_o = 2'h0;
        boot_sel_o = 2'h0;
        pll_clk_o = 1'b0;
        test_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
    end

    // Free-running and unrelated in phase to the system clock
    always #7 pll_clk_o = ~pll_clk_o;

    task automatic power(input logic [1:0] r, input logic [1:0] b);
        @(posedge sys_clk_i);
        clk_ratio_o <= r;
        boot_sel_o <= b;
        @(posedge sys_clk_i);
        proc_reset_n_o <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        proc_reset_n_o <= 1'b1;
    endtask

    // Slow test clock so the synchroniser sees every phase
    task automatic tck_cyc(input logic m, output logic d);
        test_o.tms <= m;
        repeat (8) @(posedge sys_clk_i);
        test_o.tck <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        test_o.tck <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        d = tdo_i;
    endtask

    // pull the test-port reset low again
    task automatic test_reset();
        @(posedge sys_clk_i);
        test_o.trst_n <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask

    // Low byte is the captured word, high byte the data-in bits behind it
    task automatic scan(output logic [15:0] v);
        logic d;
        @(posedge sys_clk_i);
        test_o.trst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            tck_cyc(i < 5 || i == 6, d);
        for (int i = 0; i < 16; i++)
        begin
            v[i] = d;
            tck_cyc(1'b0, d);
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
    import startup_pkg::*;
;
    localparam int LOCK = 8;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0, rd = 1'b0, prst_n, pll_clk, tdo, core_rst, fst, cro;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, faddr;
    logic [1:0]  ratio, boot, bmode, div;
    logic [5:0]  mult;
    test_pins_t  tp;
    int          mismatches = 0, checks_done = 0;

    always #5 sys_clk = ~sys_clk;

    board_model u_board (.sys_clk_i(sys_clk), .proc_reset_n_o(prst_n),
        .clk_ratio_o(ratio), .boot_sel_o(boot), .pll_clk_o(pll_clk),
        .test_o(tp), .tdo_i(tdo));

    reset_boot_clock_startup #(.LOCK_COUNT(LOCK)) i_reset_boot_clock_startup (
        .sys_clk_i(sys_clk), .rst_i(rst), .proc_reset_n_i(prst_n),
        .clk_ratio_pins_i(ratio), .boot_select_pins_i(boot),
        .pll_clk_i(pll_clk), .test_clk_i(tp.tck), .test_mode_sel_i(tp.tms),
        .test_data_i(tp.tdi), .test_reset_n_i(tp.trst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .core_reset_o(core_rst), .fetch_start_o(fst), .fetch_addr_o(faddr),
        .boot_mode_o(bmode), .pll_mult_o(mult), .pll_div_o(div),
        .clock_or_reset_out_o(cro), .test_data_o(tdo));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic [5:0] exp_mult(input logic [1:0] r);
        return r == 2'h1 ? 6'h20 : r == 2'h2 ? 6'h10 : 6'h06;
    endfunction

    initial
    begin
        logic [31:0] d, w;
        logic [15:0] v;
        logic [1:0]  r, b;
        int          seed, n;
        seed = 97308;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd_reg(STATUS_ADDR, d);
        chk(d[5], 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            r = i[1:0];
            b = 2'($random(seed));
            u_board.power(r, b);
            // Refused while the core is still held, before the lock wait starts
            wr_reg(PMCR_ADDR, 32'h3ff);
            #1 chk(core_rst, 1'b1);
            chk(cro, 1'b0);
            n = 2;
            while (fst !== 1'b1 && n < 100)
            begin
                @(posedge sys_clk);
                #1 n++;
            end
            if (n >= 100)
            begin
                mismatches++;
                give_verdict();
            end
            chk(n >= LOCK && n <= LOCK + 6, 1'b1);
            chk(faddr, RESET_VECTOR);
            chk(core_rst, 1'b0);
            chk(bmode, b);
            chk(mult, exp_mult(r));
            rd_reg(PMCR_ADDR, d);
            chk(d, {26'h0, exp_mult(r)});
            w = $random(seed) & 32'h33f;
            wr_reg(PMCR_ADDR, w);
            rd_reg(PMCR_ADDR, d);
            chk(d, w);
            chk({div, mult}, {w[9:8], w[5:0]});
            wr_reg(STATUS_ADDR, 32'h0);
            rd_reg(STATUS_ADDR, d);
            chk(d[4:0], {1'b1, b, r});
            rd_reg(4'h8, d);
            chk(d, 32'h0);
            $display("power cycle %0d done", i);
        end
        u_board.scan(v);
        chk(v[7:0], {4'h0, b, r});
        chk(v[15:8], 8'hff);
        rd_reg(STATUS_ADDR, d);
        chk(d[5], 1'b0);
        u_board.test_reset();
        rd_reg(STATUS_ADDR, d);
        chk(d[5], 1'b1);
        $display("scan done");
        chk(cro, 1'b1);
        wr_reg(PMCR_ADDR, 32'h1000);
        n = 0;
        repeat (40)
        begin
            @(posedge sys_clk);
            #1 d[0] = cro;
            @(posedge sys_clk);
            #1 n += int'(d[0] !== cro);
        end
        chk(n > 0, 1'b1);
        $display("clock out done");
        give_verdict();
    end
endmodule
`default_nettype wire
